// ==== hdl/ccpi_consts.vh ====
/*
 * constants of the codec clock, pll and start-up controller:
 * register offsets, field positions, reset values, timing counts.
 * assumes the includer works on the 10 MHz system clock.
 */
`ifndef CCPI_CONSTS_VH
`define CCPI_CONSTS_VH

// register offsets
`define CCPI_REG_CLOCK_CONTROL 8'h00
`define CCPI_REG_PLL_DEN_HIGH 8'h01
`define CCPI_REG_PLL_DEN_LOW 8'h02
`define CCPI_REG_PLL_NUM_HIGH 8'h03
`define CCPI_REG_PLL_NUM_LOW 8'h04
`define CCPI_REG_PLL_INT_DIV_MODE 8'h05
`define CCPI_REG_PLL_LOCK_STATUS 8'h06
`define CCPI_REG_LOW_GROUP_LAST 8'h06

// clock_control fields
`define CCPI_BIT_MCLK_GATE 0
`define CCPI_BIT_CORE_DIV_SEL 1
`define CCPI_BIT_CLK_SRC_SEL 3
`define CCPI_BIT_PLL_ENABLE 7

// pll_integer_divider_mode fields
`define CCPI_BIT_FRAC_MODE 0
`define CCPI_REF_DIV_LSB 1
`define CCPI_REF_DIV_MSB 2
`define CCPI_INT_FACTOR_LSB 3
`define CCPI_INT_FACTOR_MSB 6

// pll_lock_status fields
`define CCPI_BIT_PLL_LOCK 0

// reset values
`define CCPI_RST_REG 8'h00

// clock output factor codes
`define CCPI_CKO_TIMES2 3'h0
`define CCPI_CKO_TIMES1 3'h1
`define CCPI_CKO_HALF 3'h2
`define CCPI_CKO_QUARTER 3'h3
`define CCPI_CKO_EIGHTH 3'h4

// timing
`define CCPI_CLK_MHZ 10
`define CCPI_POR_TIME_US 12000
`define CCPI_POR_CYCLES (`CCPI_POR_TIME_US * `CCPI_CLK_MHZ)

`endif

// ==== hdl/ccpi_clock_output_pin_div.v ====
/*
 * clock output divider: builds the clock output level from the
 * internal master clock level by x1, 1/2, 1/4 or 1/8, and from the
 * source level for x2.
 * assumes source and master levels are sampled on clk and that
 * the caller holds it in reset while the master clock is gated.
 */
`timescale 1ns/1ns
`include "ccpi_consts.vh"

module ccpi_clock_output_pin_div (
    // clock and reset
    input wire clk,
    input wire nrst,
    // clock levels
    input wire srcLvl,
    input wire mclkLvl,
    // control
    input wire coreDivBy1,
    input wire [2:0] factorSel,
    input wire pdmMode,
    // output
    output reg clock_output_pin_q
);

reg mclkPrev_q;
reg [2:0] cnt_q;
reg clock_output_pin_d;

always @(posedge clk) begin
    if (!nrst) begin
        mclkPrev_q <= 1'b0;
        cnt_q <= 3'h0;
        clock_output_pin_q <= 1'b0;
    end else begin
        mclkPrev_q <= mclkLvl;
        if (mclkLvl && !mclkPrev_q) begin
            cnt_q <= cnt_q + 3'h1;
        end
        clock_output_pin_q <= clock_output_pin_d;
    end
end

always @* begin
    case (factorSel)
        // x2 is the undivided source, only sane after a divide by 2
        `CCPI_CKO_TIMES2: clock_output_pin_d = srcLvl & ~coreDivBy1; // [RULE19]
        `CCPI_CKO_TIMES1: clock_output_pin_d = mclkLvl; // [RULE17]
        `CCPI_CKO_HALF: clock_output_pin_d = cnt_q[0]; // [RULE17]
        `CCPI_CKO_QUARTER: clock_output_pin_d = cnt_q[1];
        `CCPI_CKO_EIGHTH: clock_output_pin_d = cnt_q[2];
        default: clock_output_pin_d = 1'b0;
    endcase
    // microphones only see the divided settings
    if (pdmMode && (factorSel == `CCPI_CKO_TIMES2 ||
            factorSel == `CCPI_CKO_TIMES1)) begin
        clock_output_pin_d = 1'b0; // [RULE18]
    end
end

endmodule // ccpi_clock_output_pin_div

// ==== hdl/ccpi_clock_ctrl.v ====
/*
 * codec clock, pll and start-up controller: low register group
 * 0x00..0x06, power-on reset timer, source mux, core divider,
 * master clock gate, access gating and clock output pin mux.
 * assumes an analog pll macro outside takes the parameters and
 * returns a lock level, resynchronized here, and an output level.
 */
// Function
// RULE1 - host sets clocks first, then converters and pins, then ports.
// RULE2 - only registers 0x00..0x06 reachable until gate and lock set; in bypass the code opens on the gate alone.
// RULE3 - bit 0 of 0x00 enables the crystal oscillator and gate.
// RULE4 - host programs the pll for exactly 24.576 MHz output.
// RULE5 - bypass only with a 12.288 or 24.576 MHz reference.
// RULE6 - bit 1 of 0x00: 1 divides by one, 0 by two.
// RULE7 - divider fixed after setup; source select may switch live.
// RULE8 - internal reset released 12 ms after power up.
// RULE9 - master clock gate resets off, stays off until lock; the code runs it without lock when the reference is selected.
// RULE10 - pll lock reported in bit 0 of register 0x06.
// RULE11 - host: pll off, write 0x01..0x05, pll on, poll, gate on.
// RULE12 - reference divided by field 0x05[2:1] plus one.
// RULE13 - integer mode ignores numerator and denominator.
// RULE14 - host keeps fraction between 0.1 and 0.9.
// RULE15 - host keeps pll output between 20.5 and 27 MHz.
// RULE16 - reference from 8 to 27 MHz accepted.
// RULE17 - clock output derived from master clock by chosen factor.
// RULE18 - in pdm mode only fractional factors toggle the output.
// RULE19 - factor two valid only with divide by two.
// RULE20 - clock output on the shared pin disables serial data.
// RULE21 - power-down pin low powers everything down.
// RULE22 - power-good on a pin can mute both dacs.
// RULE23 - pll out = ref/(x+1) * (r + n/m) / 2.
// RULE24 - 0x05 holds r[6:3], frac[0]; m in 0x01/0x02, n in 0x03/0x04.
`timescale 1ns/1ns
`include "ccpi_consts.vh"

module ccpi_clock_ctrl #(
    parameter POR_CYCLES = `CCPI_POR_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // control port
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata_q,
    output reg regAck_q,
    output reg regErr_q,
    // forwarded access to the upper register groups
    output wire extWr,
    output wire extRd,
    input wire [7:0] extRdata,
    // pins
    input wire powerDownPinN,
    input wire referenceClockPin,
    output wire xtalOscEnable,
    output reg clockOutputPin_q,
    output wire clockOutputPinOe,
    // shared pin mux and plain controls
    input wire captureSerialOutSecond,
    input wire clkOutSelect,
    input wire [2:0] clkOutFactor,
    input wire pdmMode,
    input wire powerGood,
    input wire powerGoodMuteEn,
    output wire dacMute,
    // analog pll macro
    output wire pllEnable,
    output wire [1:0] pllRefDiv,
    output wire [3:0] pllIntFactor,
    output wire [15:0] pllNumerator,
    output wire [15:0] pllDenominator,
    output wire pllFracMode,
    input wire pllLockRaw,
    input wire pllClkLvl,
    // internal clock and reset
    output reg masterClk_q,
    output wire internalRstN,
    output wire powerDownActive
);

// cut to the counter width on purpose; the default fits in 24 bits
localparam [31:0] POR_WIDE = POR_CYCLES - 1;
localparam [23:0] POR_LAST = POR_WIDE[23:0];

reg [7:0] clkCtl_q;
reg [7:0] denHi_q;
reg [7:0] denLo_q;
reg [7:0] numHi_q;
reg [7:0] numLo_q;
reg [7:0] intDiv_q;
reg [23:0] porCnt_q;
reg porDone_q;
reg lockMeta_q;
reg lockSync_q;
reg srcPrev_q;
reg srcHalf_q;
reg [7:0] rdData_d;

wire hardRst;
wire mclkGate;
wire coreDivBy1;
wire srcSelPll;
wire lockFlag;
wire lowGroup;
wire accessOk;
wire regReq;
wire srcLvl;
wire mclkRaw;
wire mclkRun;
wire cloutLvl;
wire wrTake;
wire rdTake;
wire extOk;

// pin low stops every circuit and restarts the reset timer
assign hardRst = !nrst || !powerDownPinN; // [RULE21]
assign powerDownActive = !powerDownPinN; // [RULE21]
assign internalRstN = porDone_q;

assign mclkGate = clkCtl_q[`CCPI_BIT_MCLK_GATE];
assign coreDivBy1 = clkCtl_q[`CCPI_BIT_CORE_DIV_SEL];
assign srcSelPll = clkCtl_q[`CCPI_BIT_CLK_SRC_SEL];

// the crystal runs only with the gate bit set
assign xtalOscEnable = mclkGate; // [RULE3]

// power-on reset timer
always @(posedge clk) begin
    if (hardRst) begin
        porCnt_q <= 24'h000000;
        porDone_q <= 1'b0;
    end else if (!porDone_q) begin
        if (porCnt_q == POR_LAST) begin
            porDone_q <= 1'b1; // [RULE8]
        end else begin
            porCnt_q <= porCnt_q + 24'h000001;
        end
    end
end

// pll parameters to the macro
assign pllEnable = clkCtl_q[`CCPI_BIT_PLL_ENABLE];
assign pllRefDiv = intDiv_q[`CCPI_REF_DIV_MSB:`CCPI_REF_DIV_LSB]; // [RULE12]
assign pllIntFactor =
    intDiv_q[`CCPI_INT_FACTOR_MSB:`CCPI_INT_FACTOR_LSB]; // [RULE24]
assign pllFracMode = intDiv_q[`CCPI_BIT_FRAC_MODE]; // [RULE24]
// zero fraction in integer mode keeps the macro at r/2 per divided reference
assign pllNumerator =
    pllFracMode ? {numHi_q, numLo_q} : 16'h0000; // [RULE13] [RULE23]
assign pllDenominator =
    pllFracMode ? {denHi_q, denLo_q} : 16'h0000; // [RULE13] [RULE24]

// lock from the analog side crosses in through two flops
always @(posedge clk) begin
    if (hardRst) begin
        lockMeta_q <= 1'b0;
        lockSync_q <= 1'b0;
    end else begin
        lockMeta_q <= pllLockRaw;
        lockSync_q <= lockMeta_q;
    end
end
assign lockFlag = lockSync_q && pllEnable; // [RULE10]

// source mux may switch while running; no glitch filter here
assign srcLvl = srcSelPll ? pllClkLvl : referenceClockPin; // [RULE7] [RULE16]

// divide by two on source rising edges
always @(posedge clk) begin
    if (hardRst) begin
        srcPrev_q <= 1'b0;
        srcHalf_q <= 1'b0;
    end else begin
        srcPrev_q <= srcLvl;
        if (srcLvl && !srcPrev_q) begin
            srcHalf_q <= !srcHalf_q;
        end
    end
end
assign mclkRaw = coreDivBy1 ? srcLvl : srcHalf_q; // [RULE6] [RULE5]

// gate held shut while the pll path is still acquiring
assign mclkRun = mclkGate && porDone_q && (!srcSelPll || lockFlag); // [RULE9]

always @(posedge clk) begin
    if (hardRst) begin
        masterClk_q <= 1'b0;
    end else begin
        masterClk_q <= mclkRaw && mclkRun;
    end
end

ccpi_clock_output_pin_div u_clock_output_pin (
    .clk(clk),
    .nrst(!hardRst && mclkRun),
    .srcLvl(srcLvl && mclkRun),
    .mclkLvl(masterClk_q),
    .coreDivBy1(coreDivBy1),
    .factorSel(clkOutFactor),
    .pdmMode(pdmMode),
    .clock_output_pin_q(cloutLvl)
);

// shared pin: clock output wins over the serial data
always @(posedge clk) begin
    if (hardRst) begin
        clockOutputPin_q <= 1'b0;
    end else begin
        clockOutputPin_q <= clkOutSelect ? cloutLvl :
            captureSerialOutSecond; // [RULE20]
    end
end
assign clockOutputPinOe = porDone_q;

// power-good drop mutes both converters while powerGoodMuteEn is set
assign dacMute = powerGoodMuteEn && !powerGood; // [RULE22]

// access gating
// requests before the reset timer expires are dropped silently
assign regReq = (regWr || regRd) && porDone_q;
assign wrTake = regWr && porDone_q;
// a write wins when both strobes come together
assign rdTake = regRd && porDone_q && !regWr;
assign lowGroup = regAddr <= `CCPI_REG_LOW_GROUP_LAST; // [RULE2]
// bypass has no lock to wait for, so the gate alone opens it
assign accessOk = mclkGate && (lockFlag || !srcSelPll); // [RULE2]

// upper group only once the clock path is trusted
assign extOk = porDone_q && !lowGroup && accessOk;
assign extWr = regWr && extOk; // [RULE2]
assign extRd = regRd && !regWr && extOk;

// low group register writes
always @(posedge clk) begin
    if (hardRst) begin
        clkCtl_q <= `CCPI_RST_REG; // [RULE9]
        denHi_q <= `CCPI_RST_REG;
        denLo_q <= `CCPI_RST_REG;
        numHi_q <= `CCPI_RST_REG;
        numLo_q <= `CCPI_RST_REG;
        intDiv_q <= `CCPI_RST_REG;
    end else if (wrTake) begin
        case (regAddr)
            `CCPI_REG_CLOCK_CONTROL: clkCtl_q <= regWdata; // [RULE3]
            `CCPI_REG_PLL_DEN_HIGH: denHi_q <= regWdata; // [RULE24]
            `CCPI_REG_PLL_DEN_LOW: denLo_q <= regWdata;
            `CCPI_REG_PLL_NUM_HIGH: numHi_q <= regWdata;
            `CCPI_REG_PLL_NUM_LOW: numLo_q <= regWdata;
            `CCPI_REG_PLL_INT_DIV_MODE: intDiv_q <= regWdata;
            default: ;
        endcase
    end
end

always @* begin
    case (regAddr)
        `CCPI_REG_CLOCK_CONTROL: rdData_d = clkCtl_q;
        `CCPI_REG_PLL_DEN_HIGH: rdData_d = denHi_q;
        `CCPI_REG_PLL_DEN_LOW: rdData_d = denLo_q;
        `CCPI_REG_PLL_NUM_HIGH: rdData_d = numHi_q;
        `CCPI_REG_PLL_NUM_LOW: rdData_d = numLo_q;
        `CCPI_REG_PLL_INT_DIV_MODE: rdData_d = intDiv_q;
        `CCPI_REG_PLL_LOCK_STATUS: rdData_d = {7'h00, lockFlag}; // [RULE10]
        default: rdData_d = accessOk ? extRdata : 8'h00;
    endcase
end

// answer one cycle after the request
always @(posedge clk) begin
    if (hardRst) begin
        regAck_q <= 1'b0;
        regErr_q <= 1'b0;
    end else begin
        regAck_q <= regReq;
        regErr_q <= regReq && !lowGroup && !accessOk; // [RULE2]
    end
end

// read data holds until the next read, so the host may fetch it late
always @(posedge clk) begin
    if (hardRst) begin
        regRdata_q <= 8'h00;
    end else if (rdTake) begin
        regRdata_q <= rdData_d;
    end
end

endmodule // ccpi_clock_ctrl

// ==== sim/ccpi_pll_model.sv ====
/* pll macro model: lock level after a settable delay,
   output level toggling while enabled.
   assumes it runs on the system clock. */
`timescale 1ns/1ns
module ccpi_pll_model (
    // clock
    input wire logic clk,
    // control
    input wire logic pllEnable,
    input wire logic [7:0] lockDelay,
    // status
    output logic pllLockRaw,
    output logic pllClkLvl
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk) begin
        // saturates, so a long enable never relocks by wrap
        cnt_q <= pllEnable ? cnt_q + {7'h00, cnt_q != 8'hff} : 8'h00;
        pllLockRaw <= pllEnable && cnt_q >= lockDelay;
        pllClkLvl <= pllEnable & ~pllClkLvl;
    end
endmodule // ccpi_pll_model

// ==== sim/ccpi_clock_ctrl_chk.sv ====
/* port assertions of the clock controller.
   assumes a bind onto ccpi_clock_ctrl, one clock. */
`timescale 1ns/1ns
module ccpi_clock_ctrl_chk #(
    parameter POR_CYCLES = 20
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // control port
    input wire [7:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire regAck_q,
    input wire regErr_q,
    input wire extWr,
    input wire extRd,
    // pins and status
    input wire powerDownPinN,
    input wire xtalOscEnable,
    input wire powerGood,
    input wire powerGoodMuteEn,
    input wire dacMute,
    input wire [15:0] pllNumerator,
    input wire [15:0] pllDenominator,
    input wire pllFracMode,
    input wire masterClk_q,
    input wire internalRstN
);
    int cnt_q = 0;
    wire req = (regWr | regRd) & internalRstN & powerDownPinN;
    always @(posedge clk) begin
        cnt_q <= (nrst && powerDownPinN) ? cnt_q + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ack; req |=> regAck_q; endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_early; !internalRstN |=> !regAck_q; endproperty
    a_early: assert property (p_early) else $error("early ack");
    property p_low; req && regAddr <= 8'h06 |=> !regErr_q; endproperty
    a_low: assert property (p_low) else $error("low refused");
    property p_ext; extWr | extRd |-> regAddr > 8'h06 && xtalOscEnable;
    endproperty
    a_ext: assert property (p_ext) else $error("bad fwd");
    property p_shut; req && regAddr > 8'h06 && !xtalOscEnable |=> regErr_q;
    endproperty
    a_shut: assert property (p_shut) else $error("not refused");
    property p_gate; !xtalOscEnable |=> !masterClk_q; endproperty
    a_gate: assert property (p_gate) else $error("clock leak");
    property p_porLate; cnt_q > POR_CYCLES |-> internalRstN; endproperty
    a_porLate: assert property (p_porLate) else $error("late");
    property p_porEarly; internalRstN |-> cnt_q >= POR_CYCLES - 1;
    endproperty
    a_porEarly: assert property (p_porEarly) else $error("early");
    property p_pd; !powerDownPinN |=> !internalRstN && !masterClk_q;
    endproperty
    a_pd: assert property (p_pd) else $error("still up");
    property p_mute; dacMute == (powerGoodMuteEn && !powerGood); endproperty
    a_mute: assert property (p_mute) else $error("mute");
    property p_int; !pllFracMode |-> (pllNumerator | pllDenominator) == 0;
    endproperty
    a_int: assert property (p_int) else $error("fraction");
    c_ext: cover property (extWr);
    c_err: cover property (regAck_q && regErr_q);
    c_run: cover property ($rose(masterClk_q));
endmodule // ccpi_clock_ctrl_chk
bind ccpi_clock_ctrl ccpi_clock_ctrl_chk #(.POR_CYCLES(POR_CYCLES)) i_chk (.*);

// ==== sim/ccpi_clock_ctrl_test.sv ====
/* testbench of the clock controller: registers, pll
   bring-up, source switch, mute, power-down.
   assumes the pll model stands in for the macro. */
`timescale 1ns/1ns
module ccpi_clock_ctrl_test;
    logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, extRdata = 8'ha5;
    logic [7:0] lockDelay = 8'h30, regRdata_q, pv[5];
    logic powerDownPinN = 1'b1, referenceClockPin = 1'b0, pdmMode = 1'b0;
    logic captureSerialOutSecond = 1'b0, clkOutSelect = 1'b1;
    logic powerGood = 1'b1, powerGoodMuteEn = 1'b1;
    logic [2:0] clkOutFactor = 3'h2;
    logic regAck_q, regErr_q, extWr, extRd, xtalOscEnable, dacMute;
    logic clockOutputPin_q, clockOutputPinOe, pllEnable, pllFracMode;
    logic pllLockRaw, pllClkLvl, masterClk_q, internalRstN;
    logic powerDownActive;
    logic [1:0] pllRefDiv;
    logic [3:0] pllIntFactor;
    logic [15:0] pllNumerator, pllDenominator;
    int failures = 0, check_count = 0, n, k;
    // short power-on count keeps the run small
    ccpi_clock_ctrl #(.POR_CYCLES(20)) i_ccpi_clock_ctrl (.*);
    ccpi_pll_model i_ccpi_pll_model (.*);
    always #50 clk = ~clk;
    always @(posedge clk) #1 referenceClockPin <= ~referenceClockPin;
    task chk(input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one access; d is write data or expected read data
    task acc(input logic w, input logic [7:0] a, d, input logic e, x);
        logic ext;
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWdata <= d;
        #1 ext = extWr | extRd;
        @(posedge clk) #1;
        regWr <= 1'b0;
        regRd <= 1'b0;
        chk(regAck_q, 1'b1);
        chk(regErr_q, e);
        chk(ext, x);
        if (!w) chk(regRdata_q, d);
        @(posedge clk) #1;
    endtask
    task upWait;
        for (n = 0; n < 60 && internalRstN !== 1'b1; n++) @(posedge clk);
        #1 chk(internalRstN, 1'b1);
        if (internalRstN !== 1'b1) stop_test;
    endtask
    initial begin
        pv = '{8'h06, 8'h59, 8'h04, 8'hf5, 8'h19};
        repeat (12) @(posedge clk);
        #1 nrst <= 1'b1;
        upWait;
        for (n = 0; n < 7; n++) acc(0, n[7:0], 8'h00, 0, 0);
        acc(1, 8'h10, 8'h55, 1, 0);
        acc(0, 8'h3f, 8'h00, 1, 0);
        $display("reset and refusal done");
        for (n = 0; n < 5; n++) acc(1, n[7:0] + 8'h01, pv[n], 0, 0);
        chk(pllDenominator, 16'd1625);
        chk(pllNumerator, 16'd1269);
        chk({pllIntFactor, pllRefDiv, pllFracMode}, 16'h19);
        acc(1, 8'h05, 8'h1b, 0, 0);
        chk(pllRefDiv, 2'h1);
        acc(1, 8'h05, 8'h20, 0, 0);
        chk(pllNumerator | pllDenominator, 16'h0000);
        acc(0, 8'h05, 8'h20, 0, 0);
        acc(1, 8'h00, 8'h88, 0, 0);
        for (n = 0; n < 200 && pllLockRaw !== 1'b1; n++) @(posedge clk);
        if (pllLockRaw !== 1'b1) begin
            chk(pllLockRaw, 1'b1);
            stop_test;
        end
        repeat (3) @(posedge clk);
        #1 acc(0, 8'h06, 8'h01, 0, 0);
        acc(1, 8'h10, 8'h55, 1, 0);
        acc(1, 8'h00, 8'h89, 0, 0);
        chk(xtalOscEnable, 1'b1);
        acc(1, 8'h10, 8'h5a, 0, 1);
        acc(0, 8'h20, 8'ha5, 0, 1);
        $display("pll bring-up done");
        acc(1, 8'h00, 8'h81, 0, 0);
        n = 0;
        k = 0;
        repeat (40) begin
            @(posedge clk) #1;
            n += (masterClk_q === 1'b1);
            k += (clockOutputPin_q === 1'b1);
        end
        chk(n > 4, 1'b1);
        chk(k > 2, 1'b1);
        chk(clockOutputPinOe, 1'b1);
        acc(1, 8'h11, 8'h00, 0, 1);
        pdmMode <= 1'b1;
        clkOutFactor <= 3'h1;
        repeat (3) @(posedge clk);
        k = 0;
        repeat (12) begin
            @(posedge clk) #1;
            k += (clockOutputPin_q === 1'b1);
        end
        chk(k, 0);
        clkOutSelect <= 1'b0;
        captureSerialOutSecond <= 1'b1;
        @(posedge clk) #1 chk(clockOutputPin_q, 1'b1);
        powerGood <= 1'b0;
        @(posedge clk) #1 chk(dacMute, 1'b1);
        powerDownPinN <= 1'b0;
        @(posedge clk) #1 chk(powerDownActive, 1'b1);
        powerDownPinN <= 1'b1;
        chk(internalRstN, 1'b0);
        upWait;
        acc(0, 8'h00, 8'h00, 0, 0);
        $display("switch and power-down done");
        stop_test;
    end
endmodule // ccpi_clock_ctrl_test
